// ===== hdl/odr_pkg.sv
// package: constants for the dual-role session and negotiation support logic
package odr_pkg;
   // ----------------------------------------------------------------
   // register byte addresses
   // ----------------------------------------------------------------
   localparam logic [11:0] ADDR_CTRL     = 12'h374;
   localparam logic [11:0] ADDR_STATUS   = 12'h378;
   localparam logic [11:0] ADDR_LATCH    = 12'h37C;
   localparam logic [11:0] ADDR_EN_FALL  = 12'h380;
   localparam logic [11:0] ADDR_EN_RISE  = 12'h384;
   localparam logic [11:0] ADDR_TMR_LO   = 12'h388;
   localparam logic [11:0] ADDR_TMR_HI   = 12'h38C;
   localparam logic [11:0] ADDR_PERIPH   = 12'h218;
   // ----------------------------------------------------------------
   // control bit positions
   // ----------------------------------------------------------------
   localparam int CTL_DPLUS_PULLUP_CTL   = 0;
   localparam int CTL_DM_PULLUP   = 1;
   localparam int CTL_DP_PULLDN   = 2;
   localparam int CTL_DM_PULLDN   = 3;
   localparam int CTL_DRV_VBUS    = 4;
   localparam int CTL_DISCHRG     = 5;
   localparam int CTL_CHRG        = 6;
   localparam int CTL_HOST_SEL    = 7;
   localparam int CTL_IDLE_IRQ_EN = 9;
   localparam int CTL_OTG_EN      = 10;
   localparam logic [15:0] CTRL_RESET = 16'h0000;
   // ----------------------------------------------------------------
   // status, latch, idle flag and timer bit positions
   // ----------------------------------------------------------------
   localparam int ST_ID       = 0;
   localparam int ST_SESS_VLD = 1;
   localparam int ST_DPLUS_PULSE_DETECT   = 2;
   localparam int ST_VBUS_VLD = 3;
   localparam int ST_SUSPEND  = 4;
   localparam int ST_RESUME   = 5;
   localparam int ST_OVC      = 6;
   localparam int ST_SESS_END = 7;
   localparam int ST_SE0_SRP  = 8;
   localparam int LT_TIMEOUT  = 9;
   localparam int PI_IDLE     = 0;
   localparam int TMR_RUN     = 31;
   // ----------------------------------------------------------------
   // timing
   // ----------------------------------------------------------------
   localparam int CLK_PERIOD_PS   = 5000;
   localparam int TMR_BASE_PS     = 10000000;
   localparam int TMR_TICK_CYCLES = TMR_BASE_PS / CLK_PERIOD_PS;
   localparam int SUSPEND_US      = 3000;
   localparam int SE0_SRP_US      = 2000;
   localparam int SUSPEND_CYCLES  = SUSPEND_US * 1000 / (CLK_PERIOD_PS / 1000);
   localparam int SE0_SRP_CYCLES  = SE0_SRP_US * 1000 / (CLK_PERIOD_PS / 1000);
   // ----------------------------------------------------------------
   // line monitor states
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      MON_ACTIVE  = 3'b001,
      MON_SUSPEND = 3'b010,
      MON_SE0     = 3'b100
   } odr_mon_t;
endpackage

// ===== hdl/odr_dual_role.sv
// module: dual-role port support logic with AHB-Lite register slave
//
// The AHB-Lite slave port and the register offsets were decided locally.
module odr_dual_role #(
   parameter int SUSPEND_CYC = odr_pkg::SUSPEND_CYCLES,
   parameter int SE0_SRP_CYC = odr_pkg::SE0_SRP_CYCLES
) (
   // clock and reset
   input  wire logic        hclk,
   input  wire logic        hresetn,
   // ahb-lite slave
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic [31:0]      hrdata,
   output logic             hresp,
   // port pins and comparators
   input  wire logic        plug_identity_pin,
   input  wire logic        dplus_in,
   input  wire logic        dminus_in,
   input  wire logic        sess_vld_in,
   input  wire logic        vbus_vld_in,
   input  wire logic        sess_end_in,
   input  wire logic        overcurrent_in,
   // port controls
   output logic             a_device_role,
   output logic             dplus_pullup_ctl,
   output logic             dminus_pullup_ctl,
   output logic             dplus_pulldown_ctl,
   output logic             dminus_pulldown_ctl,
   output logic             bus_power_drive,
   output logic             bus_power_charge,
   output logic             bus_power_discharge,
   output logic             host_mode,
   output logic             otg_mode
);
   // ----------------------------------------------------------------
   // pin synchronisers
   // ----------------------------------------------------------------
   localparam int NPIN = 7;
   logic [NPIN-1:0] pin_raw;
   logic [NPIN-1:0] pin_meta_reg;
   logic [NPIN-1:0] pin_sync_reg;
   assign pin_raw = {overcurrent_in, sess_end_in, vbus_vld_in, sess_vld_in,
                     dminus_in, dplus_in, plug_identity_pin};
   genvar gi;
   generate
      for (gi = 0; gi < NPIN; gi++) begin : g_sync
         // two stages per pin
         always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
               pin_meta_reg[gi] <= 1'b1;
               pin_sync_reg[gi] <= 1'b1;
            end else begin
               pin_meta_reg[gi] <= pin_raw[gi];
               pin_sync_reg[gi] <= pin_meta_reg[gi];
            end
         end
      end
   endgenerate
   logic id_s, dp_s, dm_s, sv_s, vv_s, se_s, oc_s;
   assign {oc_s, se_s, vv_s, sv_s, dm_s, dp_s, id_s} = pin_sync_reg;

   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   logic [15:0] ctrl_reg;
   logic [15:0] latch_reg;
   logic [15:0] en_fall_reg;
   logic [15:0] en_rise_reg;
   logic [31:0] tmr_reg;
   logic        idle_flag_reg;
   logic [15:0] status;
   logic [15:0] status_prev_reg;
   logic [15:0] hw_event;
   logic        tmr_done;
   logic        idle_enter;

   // ----------------------------------------------------------------
   // ahb-lite slave
   // ----------------------------------------------------------------
   logic        wr_pend_reg;
   logic        rd_pend_reg;
   logic [11:0] addr_reg;
   logic        addr_phase;
   assign addr_phase = hsel & htrans[1] & hready;

   // address phase capture, reads get one wait state
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_reg <= 1'b0;
         rd_pend_reg <= 1'b0;
         addr_reg    <= 12'h000;
         hreadyout   <= 1'b1;
         hrdata      <= 32'h0000_0000;
      end else begin
         if (addr_phase) begin
            wr_pend_reg <= hwrite;
            rd_pend_reg <= ~hwrite;
            addr_reg    <= haddr[11:0];
            hreadyout   <= hwrite;
         end else if (hready) begin
            wr_pend_reg <= 1'b0;
            rd_pend_reg <= 1'b0;
         end
         if (rd_pend_reg && !hreadyout) begin
            hrdata    <= rd_mux(addr_reg);
            hreadyout <= 1'b1;
         end
      end
   end

   // response is always okay
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hresp <= 1'b0;
      end else begin
         hresp <= 1'b0;
      end
   end

   // read mux, unmapped addresses read zero
   function automatic logic [31:0] rd_mux(input logic [11:0] a);
      logic [31:0] d;
      d = 32'h0000_0000;
      case (a)
         odr_pkg::ADDR_CTRL:    d = {16'h0000, ctrl_reg};
         odr_pkg::ADDR_STATUS:  d = {16'h0000, status};
         odr_pkg::ADDR_LATCH:   d = {16'h0000, latch_reg};
         odr_pkg::ADDR_EN_FALL: d = {16'h0000, en_fall_reg};
         odr_pkg::ADDR_EN_RISE: d = {16'h0000, en_rise_reg};
         odr_pkg::ADDR_TMR_LO:  d = {16'h0000, tmr_reg[15:0]};
         odr_pkg::ADDR_TMR_HI:  d = {16'h0000, tmr_reg[31:16]};
         odr_pkg::ADDR_PERIPH:  d = {31'h0000_0000, idle_flag_reg};
         default:               d = 32'h0000_0000;
      endcase
      return d;
   endfunction

   logic wr_ctrl, wr_latch, wr_fall, wr_rise, wr_tlo, wr_thi, wr_peri;
   assign wr_ctrl  = wr_pend_reg && addr_reg == odr_pkg::ADDR_CTRL;
   assign wr_latch = wr_pend_reg && addr_reg == odr_pkg::ADDR_LATCH;
   assign wr_fall  = wr_pend_reg && addr_reg == odr_pkg::ADDR_EN_FALL;
   assign wr_rise  = wr_pend_reg && addr_reg == odr_pkg::ADDR_EN_RISE;
   assign wr_tlo   = wr_pend_reg && addr_reg == odr_pkg::ADDR_TMR_LO;
   assign wr_thi   = wr_pend_reg && addr_reg == odr_pkg::ADDR_TMR_HI;
   assign wr_peri  = wr_pend_reg && addr_reg == odr_pkg::ADDR_PERIPH;

   // set half in low word, clear half in high word, clear wins
   function automatic logic [15:0] setclr(input logic [15:0] cur, input logic [31:0] w);
      return (cur | w[15:0]) & ~w[31:16];
   endfunction

   // control register
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ctrl_reg <= odr_pkg::CTRL_RESET;
      end else if (wr_ctrl) begin
         ctrl_reg <= setclr(ctrl_reg, hwdata);
      end
   end

   // interrupt enables
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         en_fall_reg <= 16'h0000;
         en_rise_reg <= 16'h0000;
      end else begin
         if (wr_fall) en_fall_reg <= setclr(en_fall_reg, hwdata);
         if (wr_rise) en_rise_reg <= setclr(en_rise_reg, hwdata);
      end
   end

   // ----------------------------------------------------------------
   // line monitor
   // ----------------------------------------------------------------
   odr_pkg::odr_mon_t mon_reg;
   logic [19:0] idle_cnt_reg;
   logic [1:0]  line_prev_reg;
   logic        j_state, se0_state, k_state;
   assign j_state   = dp_s & ~dm_s;
   assign se0_state = ~dp_s & ~dm_s;
   assign k_state   = ~dp_s & dm_s;

   // counts cycles without a line change
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         idle_cnt_reg  <= 20'h00000;
         line_prev_reg <= 2'b00;
      end else begin
         line_prev_reg <= {dm_s, dp_s};
         if ({dm_s, dp_s} != line_prev_reg) idle_cnt_reg <= 20'h00000;
         else if (idle_cnt_reg != 20'hFFFFF) idle_cnt_reg <= idle_cnt_reg + 20'h00001;
      end
   end

   // idle j is suspend, long se0 is the line-idle request condition
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         mon_reg <= odr_pkg::MON_ACTIVE;
      end else begin
         case (mon_reg)
            odr_pkg::MON_ACTIVE: begin
               if (j_state && idle_cnt_reg >= 20'(SUSPEND_CYC))
                  mon_reg <= odr_pkg::MON_SUSPEND;
               else if (se0_state && idle_cnt_reg >= 20'(SE0_SRP_CYC))
                  mon_reg <= odr_pkg::MON_SE0;
            end
            odr_pkg::MON_SUSPEND: begin
               if (!j_state) mon_reg <= odr_pkg::MON_ACTIVE;
            end
            odr_pkg::MON_SE0: begin
               if (!se0_state) mon_reg <= odr_pkg::MON_ACTIVE;
            end
            default: mon_reg <= odr_pkg::MON_ACTIVE;
         endcase
      end
   end
   assign idle_enter = mon_reg != odr_pkg::MON_SUSPEND && j_state &&
                       idle_cnt_reg >= 20'(SUSPEND_CYC) && mon_reg == odr_pkg::MON_ACTIVE;

   // resume seen while suspended
   logic resume_reg;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         resume_reg <= 1'b0;
      end else if (mon_reg == odr_pkg::MON_SUSPEND && k_state) begin
         resume_reg <= 1'b1;
      end else if (mon_reg == odr_pkg::MON_ACTIVE && !k_state) begin
         resume_reg <= 1'b0;
      end
   end

   // peripheral bus idle flag, set wins over write-one clear
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         idle_flag_reg <= 1'b0;
      end else begin
         idle_flag_reg <= (idle_flag_reg & ~(wr_peri & hwdata[odr_pkg::PI_IDLE])) |
                          (idle_enter & ctrl_reg[odr_pkg::CTL_IDLE_IRQ_EN]);
      end
   end

   // ----------------------------------------------------------------
   // status and latch
   // ----------------------------------------------------------------
   logic dplus_pulse_detect;
   // d+ only, seen as a-device while not powering the bus
   assign dplus_pulse_detect = ~id_s & dp_s & ~ctrl_reg[odr_pkg::CTL_DRV_VBUS];
   always_comb begin
      status = 16'h0000;
      status[odr_pkg::ST_ID]       = id_s;
      status[odr_pkg::ST_SESS_VLD] = sv_s;
      status[odr_pkg::ST_DPLUS_PULSE_DETECT]   = dplus_pulse_detect;
      status[odr_pkg::ST_VBUS_VLD] = vv_s;
      status[odr_pkg::ST_SUSPEND]  = mon_reg == odr_pkg::MON_SUSPEND;
      status[odr_pkg::ST_RESUME]   = resume_reg;
      status[odr_pkg::ST_OVC]      = oc_s;
      status[odr_pkg::ST_SESS_END] = se_s;
      status[odr_pkg::ST_SE0_SRP]  = mon_reg == odr_pkg::MON_SE0;
   end

   // previous status for edge detection
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         status_prev_reg <= 16'h0000;
      end else begin
         status_prev_reg <= status;
      end
   end

   // rise and fall events gated by the enables
   always_comb begin
      hw_event = (status & ~status_prev_reg & en_rise_reg) |
                 (~status & status_prev_reg & en_fall_reg);
      hw_event[odr_pkg::LT_TIMEOUT] = tmr_done;
   end

   // latch: event set wins over software clear
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         latch_reg <= 16'h0000;
      end else if (wr_latch) begin
         latch_reg <= setclr(latch_reg, hwdata) | hw_event;
      end else begin
         latch_reg <= latch_reg | hw_event;
      end
   end

   // ----------------------------------------------------------------
   // programmable timer
   // ----------------------------------------------------------------
   logic [11:0] tick_cnt_reg;
   logic [23:0] unit_cnt_reg;
   localparam logic [11:0] TICK_LAST = 12'(odr_pkg::TMR_TICK_CYCLES - 1);
   assign tmr_done = tmr_reg[odr_pkg::TMR_RUN] && tick_cnt_reg == TICK_LAST &&
                     unit_cnt_reg + 24'h000001 >= tmr_reg[23:0];

   // timer word: software starts and stops, hardware stops at time-out
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         tmr_reg <= 32'h0000_0000;
      end else begin
         if (wr_tlo) tmr_reg[15:0] <= setclr(tmr_reg[15:0], hwdata);
         if (wr_thi) tmr_reg[31:16] <= setclr(tmr_reg[31:16], hwdata);
         if (tmr_done) tmr_reg[odr_pkg::TMR_RUN] <= 1'b0;
      end
   end

   // base tick of 0.01 ms counted in clock cycles
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         tick_cnt_reg <= 12'h000;
         unit_cnt_reg <= 24'h000000;
      end else if (!tmr_reg[odr_pkg::TMR_RUN]) begin
         tick_cnt_reg <= 12'h000;
         unit_cnt_reg <= 24'h000000;
      end else if (tick_cnt_reg == TICK_LAST) begin
         tick_cnt_reg <= 12'h000;
         unit_cnt_reg <= unit_cnt_reg + 24'h000001;
      end else begin
         tick_cnt_reg <= tick_cnt_reg + 12'h001;
      end
   end

   // ----------------------------------------------------------------
   // port control outputs
   // ----------------------------------------------------------------
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         a_device_role       <= 1'b0;
         dplus_pullup_ctl    <= 1'b0;
         dminus_pullup_ctl   <= 1'b0;
         dplus_pulldown_ctl  <= 1'b0;
         dminus_pulldown_ctl <= 1'b0;
         bus_power_drive     <= 1'b0;
         bus_power_charge    <= 1'b0;
         bus_power_discharge <= 1'b0;
         host_mode           <= 1'b0;
         otg_mode            <= 1'b0;
      end else begin
         a_device_role       <= ~id_s;
         dplus_pullup_ctl    <= ctrl_reg[odr_pkg::CTL_DPLUS_PULLUP_CTL];
         dminus_pullup_ctl   <= ctrl_reg[odr_pkg::CTL_DM_PULLUP];
         dplus_pulldown_ctl  <= ctrl_reg[odr_pkg::CTL_DP_PULLDN];
         dminus_pulldown_ctl <= ctrl_reg[odr_pkg::CTL_DM_PULLDN];
         bus_power_drive     <= ctrl_reg[odr_pkg::CTL_DRV_VBUS] & ~id_s;
         bus_power_charge    <= ctrl_reg[odr_pkg::CTL_CHRG];
         bus_power_discharge <= ctrl_reg[odr_pkg::CTL_DISCHRG];
         host_mode           <= ctrl_reg[odr_pkg::CTL_OTG_EN] ? ~id_s
                                : ctrl_reg[odr_pkg::CTL_HOST_SEL];
         otg_mode            <= ctrl_reg[odr_pkg::CTL_OTG_EN];
      end
   end

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   chk_role_follows_id: assert property (@(posedge hclk) disable iff (!hresetn)
      id_s |=> !a_device_role) else $error("role not B after id high");
   chk_vbus_only_a: assert property (@(posedge hclk) disable iff (!hresetn)
      bus_power_drive |-> $past(!id_s)) else $error("bus power driven as B");
   chk_latch_vld_rise: assert property (@(posedge hclk) disable iff (!hresetn)
      (en_rise_reg[odr_pkg::ST_SESS_VLD] && $rose(sv_s)) |=> ##1
      latch_reg[odr_pkg::ST_SESS_VLD]) else $error("session valid rise lost");
   chk_latch_vld_fall: assert property (@(posedge hclk) disable iff (!hresetn)
      (en_fall_reg[odr_pkg::ST_SESS_VLD] && $fell(sv_s)) |=> ##1
      latch_reg[odr_pkg::ST_SESS_VLD]) else $error("session valid fall lost");
   chk_dp_pulse_line: assert property (@(posedge hclk) disable iff (!hresetn)
      status[odr_pkg::ST_DPLUS_PULSE_DETECT] |-> dp_s && !id_s) else $error("pulse not on d+");
   chk_dp_pulse_latch: assert property (@(posedge hclk) disable iff (!hresetn)
      (en_rise_reg[odr_pkg::ST_DPLUS_PULSE_DETECT] && $rose(dplus_pulse_detect)) |=> ##1
      latch_reg[odr_pkg::ST_DPLUS_PULSE_DETECT]) else $error("d+ pulse not latched");
   chk_timer_timeout: assert property (@(posedge hclk) disable iff (!hresetn)
      tmr_done |=> latch_reg[odr_pkg::LT_TIMEOUT] && !tmr_reg[odr_pkg::TMR_RUN])
      else $error("timeout not latched");
   chk_ctrl_set_clear: assert property (@(posedge hclk) disable iff (!hresetn)
      (wr_ctrl && hwdata[odr_pkg::CTL_DPLUS_PULLUP_CTL] && !hwdata[16]) |=> ##1
      dplus_pullup_ctl) else $error("pull-up set not applied");
   chk_ctrl_clear: assert property (@(posedge hclk) disable iff (!hresetn)
      (wr_ctrl && hwdata[16 + odr_pkg::CTL_CHRG]) |=> ##1 !bus_power_charge)
      else $error("charge clear not applied");
   chk_idle_flag: assert property (@(posedge hclk) disable iff (!hresetn)
      (idle_enter && ctrl_reg[odr_pkg::CTL_IDLE_IRQ_EN]) |=> idle_flag_reg)
      else $error("bus idle flag not raised");
   chk_read_wait: assert property (@(posedge hclk) disable iff (!hresetn)
      (addr_phase && !hwrite) |=> !hreadyout ##1 hreadyout)
      else $error("read answer timing wrong");
   cov_timeout: cover property (@(posedge hclk) disable iff (!hresetn) tmr_done);
   cov_dp_pulse: cover property (@(posedge hclk) disable iff (!hresetn) $rose(dplus_pulse_detect));
   cov_suspend: cover property (@(posedge hclk) disable iff (!hresetn)
      mon_reg == odr_pkg::MON_SUSPEND);
   cov_se0_idle: cover property (@(posedge hclk) disable iff (!hresetn)
      mon_reg == odr_pkg::MON_SE0);
endmodule // odr_dual_role

// ===== testbench/odr_remote_model.sv
// remote dual-role device seen across the cable
module odr_remote_model (
   // remote device controls
   input  wire logic remote_pullup,
   input  wire logic remote_charge,
   input  wire logic remote_k_state,
   // our port drives
   input  wire logic local_pullup,
   input  wire logic local_power,
   // line and comparator levels
   output logic      dplus_line,
   output logic      dminus_line,
   output logic      sess_vld_line,
   output logic      sess_end_line
);
   timeunit 1ns;
   timeprecision 1ps;
   // either pull-up gives j, none leaves se0; pulses only on d+
   // a remote k state pulls d+ low and d- high
   assign dplus_line    = (remote_pullup | local_pullup) & ~remote_k_state;
   assign dminus_line   = remote_k_state;
   // bus power from the a-device or a remote charge pulse
   assign sess_vld_line = local_power | remote_charge;
   assign sess_end_line = !sess_vld_line;
endmodule // odr_remote_model

// ===== testbench/odr_dual_role_tb.sv
// self-checking bench for the dual-role support logic
module odr_dual_role_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic        hclk, hresetn, hsel, hwrite, id, rpu, rchg, rk;
   logic [31:0] haddr, hwdata, hrdata, r;
   logic [1:0]  htrans;
   logic        hreadyout, hresp, a_dev, dpu, dmu, dpd, dmd, pwr, chg, dis, hm, om;
   logic        dp, dm, sv, se;
   int          mismatches, checks_done;
   odr_remote_model far (.remote_pullup(rpu), .remote_charge(rchg), .remote_k_state(rk),
      .local_pullup(dpu), .local_power(pwr), .dplus_line(dp), .dminus_line(dm),
      .sess_vld_line(sv), .sess_end_line(se));
   odr_dual_role #(.SUSPEND_CYC(50), .SE0_SRP_CYC(40)) dut (.hclk(hclk), .hresetn(hresetn),
      .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
      .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata),
      .hresp(hresp), .plug_identity_pin(id), .dplus_in(dp), .dminus_in(dm),
      .sess_vld_in(sv), .vbus_vld_in(sv), .sess_end_in(se), .overcurrent_in(1'b0),
      .a_device_role(a_dev), .dplus_pullup_ctl(dpu), .dminus_pullup_ctl(dmu),
      .dplus_pulldown_ctl(dpd), .dminus_pulldown_ctl(dmd), .bus_power_drive(pwr),
      .bus_power_charge(chg), .bus_power_discharge(dis), .host_mode(hm), .otg_mode(om));
   // 200 mhz clock
   initial begin
      hclk = 1'b0;
      forever #2.5 hclk = ~hclk;
   end
   // compare and count
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         mismatches++;
         $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // one single ahb-lite transfer, entered just after a rising edge
   task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
      hsel <= 1'b1; haddr <= {20'h00000, a}; htrans <= 2'h2; hwrite <= w;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      htrans <= 2'h0; hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      r = hrdata;
      chk({31'h0, hresp}, 32'h0);
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] exp, input logic [31:0] m);
      bus(1'b0, a, 32'h0);
      chk(r & m, exp);
   endtask
   // verdict and end of run
   task automatic finish_test();
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   // watchdog against a hung handshake
   initial begin
      repeat (20000) @(posedge hclk);
      mismatches++;
      finish_test();
   end
   // test sequence
   initial begin
      hresetn = 1'b0; hsel = 1'b0; haddr = 32'h0; htrans = 2'h0; hwrite = 1'b0;
      hwdata = 32'h0; id = 1'b1; rpu = 1'b0; rchg = 1'b0; rk = 1'b0;
      mismatches = 0; checks_done = 0;
      repeat (8) @(posedge hclk);
      hresetn <= 1'b1;
      repeat (3) @(posedge hclk);
      rd(odr_pkg::ADDR_CTRL, 32'h0, 32'hFFFFFFFF);
      chk({31'h0, a_dev}, 32'h0);
      bus(1'b1, odr_pkg::ADDR_CTRL, 32'h00000041);
      repeat (2) @(posedge hclk);
      chk({30'h0, dpu, chg}, 32'h3);
      bus(1'b1, odr_pkg::ADDR_CTRL, 32'h00010030);
      rd(odr_pkg::ADDR_CTRL, 32'h70, 32'hFFFFFFFF);
      chk({29'h0, dpu, dis, pwr}, 32'h2);
      id <= 1'b0;
      repeat (60) @(posedge hclk);
      chk({30'h0, a_dev, pwr}, 32'h3);
      rd(odr_pkg::ADDR_STATUS, 32'h10A, 32'h18B);
      bus(1'b1, odr_pkg::ADDR_CTRL, 32'h00500000);
      bus(1'b1, odr_pkg::ADDR_EN_RISE, 32'h6);
      bus(1'b1, odr_pkg::ADDR_EN_FALL, 32'h2);
      repeat (6) @(posedge hclk);
      bus(1'b1, odr_pkg::ADDR_LATCH, 32'hFFFF0000);
      rd(odr_pkg::ADDR_LATCH, 32'h0, 32'h6);
      rpu <= 1'b1;
      repeat (10) @(posedge hclk);
      rpu <= 1'b0;
      rd(odr_pkg::ADDR_LATCH, 32'h4, 32'h6);
      rchg <= 1'b1;
      repeat (10) @(posedge hclk);
      rchg <= 1'b0;
      rd(odr_pkg::ADDR_LATCH, 32'h6, 32'h6);
      bus(1'b1, odr_pkg::ADDR_CTRL, 32'h00000201);
      repeat (60) @(posedge hclk);
      rd(odr_pkg::ADDR_PERIPH, 32'h1, 32'h1);
      rd(odr_pkg::ADDR_STATUS, 32'h10, 32'h110);
      // remote k while suspended shows resume and leaves suspend
      rk <= 1'b1;
      repeat (4) @(posedge hclk);
      rd(odr_pkg::ADDR_STATUS, 32'h20, 32'h30);
      rk <= 1'b0;
      rd(12'h3F0, 32'h0, 32'hFFFFFFFF);
      bus(1'b1, odr_pkg::ADDR_LATCH, 32'h02000000);
      bus(1'b1, odr_pkg::ADDR_TMR_LO, 32'h1);
      bus(1'b1, odr_pkg::ADDR_TMR_HI, 32'h8000);
      repeat (1900) @(posedge hclk);
      rd(odr_pkg::ADDR_LATCH, 32'h0, 32'h200);
      repeat (100) @(posedge hclk);
      rd(odr_pkg::ADDR_LATCH, 32'h200, 32'h200);
      // remaining line controls and the host select paths
      bus(1'b1, odr_pkg::ADDR_CTRL, 32'h0000040E);
      repeat (2) @(posedge hclk);
      chk({27'h0, dmu, dpd, dmd, hm, om}, 32'h1F);
      bus(1'b1, odr_pkg::ADDR_CTRL, 32'h04000080);
      repeat (2) @(posedge hclk);
      chk({30'h0, hm, om}, 32'h2);
      bus(1'b1, odr_pkg::ADDR_CTRL, 32'h00800000);
      repeat (2) @(posedge hclk);
      chk({30'h0, hm, om}, 32'h0);
      finish_test();
   end
endmodule // odr_dual_role_tb
